/* File: design/mrp_memory_control.sv */
// Purpose: refresh, precharge, parity and diagnostic register of a two-port memory controller
// Assumes: requests held until done, matrix data valid by end of the access phase
// Notes:   refresh has top priority outside a paused-read hold, then processor port, then peripheral bus
//
// Summary of operation
// (R1) dynamic mode: 32 row refreshes per millisecond
// (R2) refresh requests arbitrate, top priority outside a paused-read hold
// (R3) precharge every read and write except paused write; refresh never precharges
// (R4) static mode: no refresh, no precharge
// (R5) word write: parity bits 16 and 17
// (R6) byte write: only that byte and parity
// (R7) processor reads checked after latch, flagged
// (R8) peripheral writes with forced parity, reads checked
// (R9) even parity normal; odd causes read error
// (R10) three-bit parity control register
// (R11) register address from lowest memory address
// (R12) peripheral bus reads and writes register
// (R13) error reported only when reporting enabled
// (R14) row counter wraps; refreshes evenly spaced
`timescale 1ns/10ps
module mrp_memory_control #(
	parameter logic [mrp_pkg::ADDR_W-1:0] MEM_BASE         = 18'h00000,
	parameter int                         REFRESH_INTERVAL = mrp_pkg::REFRESH_INTERVAL_CYC,
	parameter int                         PRECHARGE_CYC    = mrp_pkg::PRECHARGE_CYC_DEF,
	parameter int                         ACCESS_CYC       = mrp_pkg::ACCESS_CYC_DEF
) (
	// clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         reset_n,
	// matrix type strap, high for static bipolar matrices
	input  wire logic                         staticMatrixPin,
	// processor port
	input  wire logic                         procReq,
	input  wire logic                         procWrite,
	input  wire logic                         procByte,
	input  wire logic                         procPause,
	input  wire logic [mrp_pkg::ADDR_W-1:0]   procAddr,
	input  wire logic [mrp_pkg::DATA_W-1:0]   procWdata,
	output logic                              procDone,
	output logic [mrp_pkg::DATA_W-1:0]        procRdata,
	output logic                              procParityErr,
	// peripheral bus port
	input  wire logic                         periReq,
	input  wire logic                         periWrite,
	input  wire logic                         periByte,
	input  wire logic                         periIoSel,
	input  wire logic [mrp_pkg::ADDR_W-1:0]   periAddr,
	input  wire logic [mrp_pkg::DATA_W-1:0]   periWdata,
	output logic                              periDone,
	output logic [mrp_pkg::DATA_W-1:0]        periRdata,
	// memory matrix bus
	output logic                              memSelect,
	output logic                              memWriteEn,
	output logic                              memRefresh,
	output logic [1:0]                        memByteEn,
	output logic [mrp_pkg::WADDR_W-1:0]       memAddr,
	output logic [mrp_pkg::WORD_W-1:0]        memWdata,
	input  wire logic [mrp_pkg::WORD_W-1:0]   memRdata
);
	localparam int TICK_W = $clog2(REFRESH_INTERVAL + 1);
	localparam int IOHI_W = mrp_pkg::WADDR_W - mrp_pkg::BANK_W;

	mrp_pkg::mrp_state_t state;
	mrp_pkg::mrp_state_t next_state;

	logic                          staticSync1;
	logic                          staticMode;
	logic [TICK_W-1:0]             tickCnt;
	logic                          refreshPending;
	logic [mrp_pkg::ROW_W-1:0]     rowCnt;
	logic [7:0]                    phaseCnt;
	logic                          curWrite;
	logic                          curSrcProc;
	logic                          curRefresh;
	logic                          curPause;
	logic                          curRegLow;
	logic                          pauseHeld;
	logic [mrp_pkg::WORD_W-1:0]    readWord;
	logic [mrp_pkg::PCR_W-1:0]     parityCtl;

	// two flops on the strap: it is an asynchronous pin level
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			staticSync1 <= 1'b0;
			staticMode  <= 1'b0;
		end else begin
			staticSync1 <= staticMatrixPin;
			staticMode  <= staticSync1;
		end
	end

	// arbitration: a paused read locks out everyone but the processor
	wire idle          = (state == mrp_pkg::ST_IDLE);
	wire tickHit       = (tickCnt == TICK_W'(REFRESH_INTERVAL - 1));
	wire refreshGrant  = idle & refreshPending & ~pauseHeld; // (R2)
	wire procGrant     = idle & procReq & ~refreshGrant; // (R2)
	wire regHit        = periIoSel
	                   & (periAddr[mrp_pkg::ADDR_W-1:1]
	                      == {mrp_pkg::PARREG_IO_BASE,
	                          MEM_BASE[mrp_pkg::ADDR_W-1 -: mrp_pkg::BANK_W]}); // (R11)
	wire periOurs      = ~periIoSel | regHit;
	wire periGrant     = idle & periReq & periOurs & ~refreshGrant & ~procReq & ~pauseHeld; // (R2)
	wire periRegGrant  = periGrant & regHit; // (R12)
	wire periMemGrant  = periGrant & ~regHit;
	wire memGrant      = procGrant | periMemGrant;

	// request source selection
	wire                        selWrite = procGrant ? procWrite : periWrite;
	wire                        selByte  = procGrant ? procByte  : periByte;
	wire [mrp_pkg::ADDR_W-1:0]  selAddr  = procGrant ? procAddr  : periAddr;
	wire [mrp_pkg::DATA_W-1:0]  selData  = procGrant ? procWdata : periWdata;
	wire                        lane     = selAddr[0];

	// write parity, both bytes computed, byte enable decides what lands
	logic lowParGen;
	logic highParGen;
	mrp_byte_parity genLow (
		.dataByte  (selData[7:0]),
		.forceOdd  (parityCtl[mrp_pkg::PCR_ODD_BIT]),
		.parityBit (lowParGen)
	); // (R8)
	mrp_byte_parity genHigh (
		.dataByte  (selData[15:8]),
		.forceOdd  (parityCtl[mrp_pkg::PCR_ODD_BIT]),
		.parityBit (highParGen)
	); // (R9)
	wire [mrp_pkg::WORD_W-1:0] selWord = {highParGen, lowParGen, selData}; // (R5)
	wire [1:0] selByteEn = selByte ? (lane ? 2'b10 : 2'b01) : 2'b11; // (R6)

	// the write that closes a paused read reuses the open row, and static parts never precharge
	wire skipPrecharge = staticMode | (procGrant & pauseHeld & procWrite); // (R3)

	// read checking always uses the even sense against the stored bits
	logic lowParChk;
	logic highParChk;
	mrp_byte_parity chkLow (
		.dataByte  (readWord[7:0]),
		.forceOdd  (1'b0),
		.parityBit (lowParChk)
	);
	mrp_byte_parity chkHigh (
		.dataByte  (readWord[15:8]),
		.forceOdd  (1'b0),
		.parityBit (highParChk)
	);
	wire parMismatch = (lowParChk  != readWord[mrp_pkg::LOW_PAR_BIT])
	                 | (highParChk != readWord[mrp_pkg::HIGH_PAR_BIT]); // (R9)
	wire inCheck     = (state == mrp_pkg::ST_CHECK);
	wire parEvent    = inCheck & parMismatch; // (R7)

	// phase timing
	wire precharged = (phaseCnt == 8'(PRECHARGE_CYC - 1));
	wire accessed   = (phaseCnt == 8'(ACCESS_CYC - 1));

	// sequencer next state
	always_comb begin
		next_state = state;
		case (state)
			mrp_pkg::ST_IDLE: begin
				if (refreshGrant) begin
					next_state = mrp_pkg::ST_ACCESS;
				end else if (periRegGrant) begin
					next_state = mrp_pkg::ST_REGOP;
				end else if (memGrant) begin
					next_state = skipPrecharge ? mrp_pkg::ST_ACCESS : mrp_pkg::ST_PRECH; // (R4)
				end
			end
			mrp_pkg::ST_PRECH: begin
				if (precharged) begin
					next_state = mrp_pkg::ST_ACCESS; // (R3)
				end
			end
			mrp_pkg::ST_ACCESS: begin
				if (accessed) begin
					next_state = (curWrite | curRefresh) ? mrp_pkg::ST_DONE : mrp_pkg::ST_CHECK;
				end
			end
			mrp_pkg::ST_CHECK: begin
				next_state = mrp_pkg::ST_DONE;
			end
			mrp_pkg::ST_REGOP: begin
				next_state = mrp_pkg::ST_DONE;
			end
			mrp_pkg::ST_DONE: begin
				next_state = mrp_pkg::ST_IDLE;
			end
			default: begin
				next_state = mrp_pkg::ST_IDLE;
			end
		endcase
	end

	wire enterAccess = (next_state == mrp_pkg::ST_ACCESS);
	wire enterDone   = (next_state == mrp_pkg::ST_DONE);
	wire writeNext   = idle ? (selWrite & memGrant) : curWrite;

	// state register and phase counter, restarted on every state change
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state    <= mrp_pkg::ST_IDLE;
			phaseCnt <= 8'h00;
		end else begin
			state    <= next_state;
			phaseCnt <= (next_state != state) ? 8'h00 : phaseCnt + 8'h01;
		end
	end

	// refresh pacing: one row per interval keeps the spread even under heavy traffic
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			tickCnt <= '0;
		end else if (staticMode || tickHit) begin
			tickCnt <= '0; // (R14)
		end else begin
			tickCnt <= tickCnt + TICK_W'(1);
		end
	end

	// a new tick wins over the grant that clears the pending flag
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			refreshPending <= 1'b0;
			rowCnt         <= '0;
		end else begin
			refreshPending <= ~staticMode & (tickHit | (refreshPending & ~refreshGrant)); // (R4)
			if (refreshGrant) begin
				rowCnt <= rowCnt + mrp_pkg::ROW_W'(1); // (R1)
			end
		end
	end

	// request latch at grant time
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			curWrite   <= 1'b0;
			curSrcProc <= 1'b0;
			curRefresh <= 1'b0;
			curPause   <= 1'b0;
			curRegLow  <= 1'b0;
		end else if (refreshGrant || memGrant || periRegGrant) begin
			curWrite   <= selWrite & ~refreshGrant;
			curSrcProc <= procGrant;
			curRefresh <= refreshGrant;
			curPause   <= procGrant & procPause & ~procWrite;
			curRegLow  <= periRegGrant & periWrite & ~(periByte & periAddr[0]);
		end
	end

	// matrix address and write word; refresh drives the row counter instead
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			memAddr    <= '0;
			memWdata   <= '0;
			memByteEn  <= 2'b00;
			memRefresh <= 1'b0;
		end else if (refreshGrant) begin
			memAddr    <= {(mrp_pkg::WADDR_W - mrp_pkg::ROW_W)'(0), rowCnt}; // (R1)
			memByteEn  <= 2'b00;
			memRefresh <= 1'b1;
		end else if (memGrant) begin
			memAddr    <= selAddr[mrp_pkg::ADDR_W-1:1];
			memWdata   <= selWord; // (R5)
			memByteEn  <= selByteEn; // (R6)
			memRefresh <= 1'b0;
		end
	end

	// strobes are high for the whole access phase
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			memSelect  <= 1'b0;
			memWriteEn <= 1'b0;
		end else begin
			memSelect  <= enterAccess;
			memWriteEn <= enterAccess & writeNext;
		end
	end

	// read word latched at the end of the access, checked in the next cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			readWord <= '0;
		end else if ((state == mrp_pkg::ST_ACCESS) && accessed && !curWrite && !curRefresh) begin
			readWord <= memRdata; // (R7)
		end
	end

	// paused read holds the memory for the processor's write; an error cancels the hold
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pauseHeld <= 1'b0;
		end else if (procGrant) begin
			pauseHeld <= 1'b0;
		end else if (inCheck && curPause) begin
			pauseHeld <= ~parMismatch;
		end
	end

	// parity control register; a new error wins over software clearing the flag
	wire regWr = (state == mrp_pkg::ST_REGOP) & curRegLow;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			parityCtl <= mrp_pkg::PCR_RESET;
		end else begin
			if (regWr) begin
				parityCtl[mrp_pkg::PCR_REPORT_BIT] <= periWdata[mrp_pkg::PCR_REPORT_BIT]; // (R10)
				parityCtl[mrp_pkg::PCR_ODD_BIT]    <= periWdata[mrp_pkg::PCR_ODD_BIT]; // (R12)
			end
			parityCtl[mrp_pkg::PCR_ERR_BIT] <= parEvent
			                                 | (regWr ? periWdata[mrp_pkg::PCR_ERR_BIT]
			                                          : parityCtl[mrp_pkg::PCR_ERR_BIT]); // (R8)
		end
	end

	// answers to the two ports, each for one cycle in the done state
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			procDone      <= 1'b0;
			periDone      <= 1'b0;
			procParityErr <= 1'b0;
		end else begin
			procDone      <= enterDone & curSrcProc & ~curRefresh;
			periDone      <= enterDone & ~curSrcProc & ~curRefresh;
			procParityErr <= parEvent & curSrcProc & parityCtl[mrp_pkg::PCR_REPORT_BIT]; // (R13)
		end
	end

	// read data returned to whichever port asked
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			procRdata <= '0;
			periRdata <= '0;
		end else if (inCheck && curSrcProc) begin
			procRdata <= readWord[mrp_pkg::DATA_W-1:0];
		end else if (inCheck) begin
			periRdata <= readWord[mrp_pkg::DATA_W-1:0];
		end else if (state == mrp_pkg::ST_REGOP) begin
			periRdata <= {(mrp_pkg::DATA_W - mrp_pkg::PCR_W)'(0), parityCtl}; // (R12)
		end
	end
endmodule

/* File: design/mrp_pkg.sv */
// Purpose: shared constants for the memory refresh, precharge and parity controller
// Assumes: byte addresses, 16-bit data words stored as 18 bits with two byte parity bits
// Notes:   all offsets, field positions, reset values and timing counts live here
package mrp_pkg;
	// address and data geometry
	localparam int ADDR_W        = 18;
	localparam int WADDR_W       = ADDR_W - 1;
	localparam int DATA_W        = 16;
	localparam int WORD_W        = 18;
	localparam int LOW_PAR_BIT   = 16;
	localparam int HIGH_PAR_BIT  = 17;
	localparam int BANK_W        = 4;
	// refresh timing
	localparam int REFRESH_ROWS      = 32;
	localparam int ROW_W             = 5;
	localparam int REFRESH_PERIOD_NS = 1000000;
	localparam int CLK_PERIOD_NS     = 4;
	// longest spacing, so rounded down
	localparam int REFRESH_INTERVAL_CYC = REFRESH_PERIOD_NS / (CLK_PERIOD_NS * REFRESH_ROWS);
	// access phase lengths in cycles
	localparam int PRECHARGE_CYC_DEF = 3;
	localparam int ACCESS_CYC_DEF    = 3;
	// parity control register fields
	localparam int         PCR_W          = 3;
	localparam int         PCR_REPORT_BIT = 0;
	localparam int         PCR_ODD_BIT    = 1;
	localparam int         PCR_ERR_BIT    = 2;
	localparam logic [2:0] PCR_RESET      = 3'h0;
	// upper word-address bits of the parity register in the peripheral I/O page
	localparam logic [12:0] PARREG_IO_BASE = 13'h1f80;
	// access sequencer states
	typedef enum logic [5:0] {
		ST_IDLE   = 6'h01,
		ST_PRECH  = 6'h02,
		ST_ACCESS = 6'h04,
		ST_CHECK  = 6'h08,
		ST_REGOP  = 6'h10,
		ST_DONE   = 6'h20
	} mrp_state_t;
endpackage

/* File: design/mrp_byte_parity.sv */
// Purpose: parity bit for one data byte
// Assumes: pure combinational, used for generation and for checking
// Notes:   even sense makes byte plus parity bit hold an even count of ones
`timescale 1ns/10ps
module mrp_byte_parity (
	// data in
	input  wire logic [7:0] dataByte,
	input  wire logic       forceOdd,
	// parity out
	output logic            parityBit
);
	// odd sense is only for planting deliberate errors
	assign parityBit = (^dataByte) ^ forceOdd;
endmodule

/* File: testbench/mrp_memory_control_chk.sv */
// Purpose: port-level assertions for the memory controller
// Assumes: strap held stable across each reset release
// Notes:   refresh spacing allows slack for one access in flight
`timescale 1ns/10ps
module mrp_memory_control_chk #(
	parameter int REFRESH_INTERVAL = 7812
) (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic        staticMatrixPin,
	// processor side
	input wire logic        procWrite,
	input wire logic        procDone,
	input wire logic [15:0] procRdata,
	input wire logic        procParityErr,
	// matrix side
	input wire logic        memSelect,
	input wire logic        memWriteEn,
	input wire logic        memRefresh,
	input wire logic [1:0]  memByteEn,
	input wire logic [16:0] memAddr,
	input wire logic [17:0] memWdata
);
	logic        lastSel;
	logic [15:0] gapCount;
	logic [4:0]  nextRow;
	wire         refStart = memSelect && memRefresh && !lastSel;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	// cycles since the last refresh, and the row that must come next
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lastSel  <= 1'b0;
			gapCount <= 16'h0;
			nextRow  <= 5'h0;
		end else begin
			lastSel  <= memSelect;
			gapCount <= (refStart || staticMatrixPin) ? 16'h0 : gapCount + 16'h1;
			if (refStart) nextRow <= memAddr[4:0] + 5'h1;
		end
	end
	a_refresh_no_data: assert property (memSelect && memRefresh |->
		memByteEn == 2'h0 && !memWriteEn) else $error("refresh cycle drove data");
	a_refresh_row_order: assert property (refStart |-> memAddr == {12'h0, nextRow})
		else $error("refresh row out of order");
	a_refresh_spacing: assert property (gapCount <= REFRESH_INTERVAL + 12)
		else $error("refresh came too late");
	a_word_parity: assert property (memSelect && memWriteEn && memByteEn == 2'h3 |->
		(memWdata[16] ^ (^memWdata[7:0])) == (memWdata[17] ^ (^memWdata[15:8])))
		else $error("byte parity bits disagree");
	a_write_lane: assert property (memSelect && memWriteEn |-> memByteEn != 2'h0)
		else $error("write with no lane");
	a_access_length: assert property ($rose(memSelect) |-> memSelect[*3] ##1 !memSelect)
		else $error("access phase length wrong");
	// three quiet cycles ahead of the access are the precharge; a skipped one leaves two
	a_read_precharge: assert property (procDone && !procWrite && !staticMatrixPin |->
		$past(memSelect, 4) && !$past(memSelect, 5) && !$past(memSelect, 6)
		&& !$past(memSelect, 7)) else $error("read without precharge");
	a_err_with_done: assert property (procParityErr |-> procDone)
		else $error("parity error outside done");
	a_done_single: assert property (procDone |=> !procDone)
		else $error("done longer than one cycle");
	a_rdata_hold: assert property ($changed(procRdata) |-> procDone)
		else $error("read data changed without done");
endmodule

bind mrp_memory_control mrp_memory_control_chk #(.REFRESH_INTERVAL(REFRESH_INTERVAL)) chk (
	.sys_clk(sys_clk), .reset_n(reset_n), .staticMatrixPin(staticMatrixPin),
	.procWrite(procWrite), .procDone(procDone), .procRdata(procRdata),
	.procParityErr(procParityErr), .memSelect(memSelect), .memWriteEn(memWriteEn),
	.memRefresh(memRefresh), .memByteEn(memByteEn), .memAddr(memAddr), .memWdata(memWdata));

/* File: testbench/mrp_matrix_model.sv */
// Purpose: behavioural memory matrix behind the controller
// Assumes: 64 words suffice; higher address bits are ignored
// Notes:   read lines toggle when not selected, so stale data never matches
`timescale 1ns/10ps
module mrp_matrix_model (
	// matrix bus
	input  wire logic        sys_clk,
	input  wire logic        memSelect,
	input  wire logic        memWriteEn,
	input  wire logic [1:0]  memByteEn,
	input  wire logic [16:0] memAddr,
	input  wire logic [17:0] memWdata,
	output logic      [17:0] memRdata
);
	logic [17:0] mem [64];
	logic [17:0] idlePat;
	wire  [5:0]  idx = memAddr[5:0];
	initial begin
		idlePat = 18'h2aaaa;
		foreach (mem[i]) mem[i] = 18'h0;
	end
	// each lane keeps its own parity bit; the other lane is untouched
	always @(posedge sys_clk) begin
		idlePat <= ~idlePat;
		if (memSelect && memWriteEn && memByteEn[0]) begin
			mem[idx][7:0] <= memWdata[7:0];
			mem[idx][16]  <= memWdata[16];
		end
		if (memSelect && memWriteEn && memByteEn[1]) begin
			mem[idx][15:8] <= memWdata[15:8];
			mem[idx][17]   <= memWdata[17];
		end
	end
	assign memRdata = (memSelect && !memWriteEn) ? mem[idx] : idlePat;
endmodule

/* File: testbench/tb_mrp_memory_control.sv */
// Purpose: self-checking bench for the refresh, precharge and parity controller
// Assumes: refresh interval shortened to 100 cycles
// Notes:   latency is judged only when no refresh slipped in first
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_mrp_memory_control;
	localparam int          RI = 100;
	localparam int          P  = 3;
	localparam int          A  = 3;
	localparam logic [17:0] REG_ADDR = {mrp_pkg::PARREG_IO_BASE, 4'h0, 1'b0};
	logic sys_clk = 0, reset_n = 0, staticMatrixPin = 0;
	logic procReq = 0, procWrite = 0, procByte = 0, procPause = 0;
	logic periReq = 0, periWrite = 0, periByte = 0, periIoSel = 0;
	logic [17:0] procAddr = 0, periAddr = 0, memWdata, memRdata;
	logic [15:0] procWdata = 0, periWdata = 0, procRdata, periRdata, pRd, rRd;
	logic procDone, procParityErr, periDone, memSelect, memWriteEn, memRefresh;
	logic pErr, rDone, selPrev = 0;
	logic [1:0] memByteEn;
	logic [16:0] memAddr;
	int err_total = 0, total_checks = 0, pLat, refCount = 0, refSnap;
	mrp_memory_control #(.REFRESH_INTERVAL(RI), .PRECHARGE_CYC(P), .ACCESS_CYC(A)) uut (
		.sys_clk(sys_clk), .reset_n(reset_n), .staticMatrixPin(staticMatrixPin),
		.procReq(procReq), .procWrite(procWrite), .procByte(procByte), .procPause(procPause),
		.procAddr(procAddr), .procWdata(procWdata), .procDone(procDone),
		.procRdata(procRdata), .procParityErr(procParityErr), .periReq(periReq),
		.periWrite(periWrite), .periByte(periByte), .periIoSel(periIoSel),
		.periAddr(periAddr), .periWdata(periWdata), .periDone(periDone),
		.periRdata(periRdata), .memSelect(memSelect), .memWriteEn(memWriteEn),
		.memRefresh(memRefresh), .memByteEn(memByteEn), .memAddr(memAddr),
		.memWdata(memWdata), .memRdata(memRdata));
	mrp_matrix_model mdl (.sys_clk(sys_clk), .memSelect(memSelect), .memWriteEn(memWriteEn),
		.memByteEn(memByteEn), .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata));
	always #2 sys_clk = ~sys_clk;
	// count refresh starts seen on the matrix bus
	always @(posedge sys_clk) begin
		if (memSelect && memRefresh && !selPrev) refCount <= refCount + 1;
		selPrev <= memSelect;
	end
	task automatic do_reset();
		@(posedge sys_clk);
		reset_n <= 1'b0;
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
	endtask
	// request held until done, dropped on the next edge
	task automatic proc_op(input logic w, b, p, input logic [17:0] a, input logic [15:0] d);
		pLat = 0;
		refSnap = refCount;
		@(posedge sys_clk);
		procReq <= 1'b1;
		procWrite <= w;
		procByte <= b;
		procPause <= p;
		procAddr <= a;
		procWdata <= d;
		while (procDone !== 1'b1 && pLat < 50) begin
			@(posedge sys_clk);
			#1;
			pLat++;
		end
		pRd = procRdata;
		pErr = procParityErr;
		@(posedge sys_clk);
		procReq <= 1'b0;
	endtask
	task automatic peri_op(input logic w, io, input logic [17:0] a, input logic [15:0] d,
		input int lim);
		int n;
		n = 0;
		@(posedge sys_clk);
		periReq <= 1'b1;
		periWrite <= w;
		periIoSel <= io;
		periAddr <= a;
		periWdata <= d;
		while (periDone !== 1'b1 && n < lim) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		rDone = (periDone === 1'b1);
		rRd = periRdata;
		@(posedge sys_clk);
		periReq <= 1'b0;
	endtask
	task automatic chk_lat(input int e);
		if (refCount == refSnap) `CHK("latency", e, pLat)
	endtask
	task automatic t_register();
		peri_op(0, 1, REG_ADDR, 16'h0, 50);
		`CHK("pcr reset", 16'h0000, rRd)
		peri_op(1, 1, REG_ADDR, 16'h0003, 50);
		peri_op(0, 1, REG_ADDR, 16'h0, 50);
		`CHK("pcr rw", 16'h0003, rRd)
		peri_op(0, 1, REG_ADDR ^ 18'h2, 16'h0, 20);
		`CHK("other io", 1'b0, rDone)
		// leave reporting on so clean reads below can show a false error
		peri_op(1, 1, REG_ADDR, 16'h0001, 50);
	endtask
	task automatic t_write_read();
		proc_op(1, 0, 0, 18'h10, 16'h0301);
		chk_lat(P + A + 1);
		`CHK("word store", {1'b0, 1'b1, 16'h0301}, mdl.mem[8])
		proc_op(0, 0, 0, 18'h10, 16'h0);
		chk_lat(P + A + 2);
		`CHK("read data", 16'h0301, pRd)
		`CHK("read err", 1'b0, pErr)
		proc_op(1, 1, 0, 18'h11, 16'hff00);
		`CHK("high byte", {1'b0, 1'b1, 16'hff01}, mdl.mem[8])
		proc_op(1, 1, 0, 18'h10, 16'h0007);
		`CHK("low byte", {1'b0, 1'b1, 16'hff07}, mdl.mem[8])
		proc_op(0, 0, 1, 18'h10, 16'h0);
		chk_lat(P + A + 2);
		proc_op(1, 0, 0, 18'h10, 16'h1234);
		chk_lat(A + 1);
	endtask
	task automatic t_diag();
		peri_op(1, 1, REG_ADDR, 16'h0003, 50);
		peri_op(1, 0, 18'h20, 16'h0001, 50);
		`CHK("odd store", {1'b1, 1'b0, 16'h0001}, mdl.mem[16])
		proc_op(0, 0, 0, 18'h20, 16'h0);
		`CHK("odd err", 1'b1, pErr)
		peri_op(0, 1, REG_ADDR, 16'h0, 50);
		`CHK("sticky", 16'h0007, rRd)
		peri_op(1, 1, REG_ADDR, 16'h0002, 50);
		proc_op(0, 0, 0, 18'h20, 16'h0);
		`CHK("masked err", 1'b0, pErr)
		peri_op(0, 0, 18'h20, 16'h0, 50);
		`CHK("peri read", 16'h0001, rRd)
		peri_op(1, 1, REG_ADDR, 16'h0000, 50);
	endtask
	task automatic t_refresh();
		refSnap = refCount;
		repeat (4 * RI) @(posedge sys_clk);
		`CHK("refresh rate", 1'b1, refCount - refSnap inside {[3:5]})
		repeat (30) proc_op(0, 0, 0, 18'h10, 16'h0);
		`CHK("busy data", 16'h1234, pRd)
	endtask
	task automatic t_static();
		staticMatrixPin <= 1'b1;
		do_reset();
		refSnap = refCount;
		proc_op(1, 0, 0, 18'h30, 16'h00aa);
		`CHK("static write", A + 1, pLat)
		proc_op(0, 0, 0, 18'h30, 16'h0);
		`CHK("static read", A + 2, pLat)
		repeat (4 * RI) @(posedge sys_clk);
		`CHK("no refresh", refSnap, refCount)
	endtask
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// watchdog sized well past the whole sequence
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_total++;
		give_verdict();
	end
	initial begin
		do_reset();
		t_register();
		t_write_read();
		t_diag();
		t_refresh();
		t_static();
		give_verdict();
	end
endmodule
